// [bwt_defines.svh]
// constants and behaviour notes for the basic watchdog / stabilization timer
//------------------------------------------------------------------------------
// Notes on behaviour
// - timer clock comes from prescaler dividing oscillator by 4096, 1024 or 128
// - eight-bit up-counter on timer clock, readable at ddh, writes ignored
// - read/write control register at dch with select, clears and disable field
// - reset clears control to zero: watchdog enabled, divide by 4096
// - watchdog disabled only while upper control nibble equals 1010b
// - counter overflow while watchdog enabled raises a system reset
// - overflow is the carry out of bit 7, wrap from ffh to 00h
// - writing one to control bit 1 clears the counter
// - writing one to control bit 0 clears the prescaler
// - reset or external interrupt in stop mode starts the stabilization count
// - after reset count at divide 4096, after interrupt at programmed select
// - counter bit 4 set ends stabilization and restores the cpu clock
// - interrupt release from stop leaves timer settings unchanged
//------------------------------------------------------------------------------
`ifndef BWT_DEFINES_SVH
`define BWT_DEFINES_SVH
`define BWT_ADDR_CTRL 8'hdc
`define BWT_ADDR_COUNT 8'hdd
`define BWT_ADDR_IRQ_STATUS 8'hde
`define BWT_ADDR_IRQ_MASK 8'hdf
`define BWT_CTRL_RESET 8'h00
`define BWT_DIS_SIG 4'ha
`define BWT_BIT_CNT_CLR 1
`define BWT_BIT_PRE_CLR 0
`define BWT_SEL_LO 2
`define BWT_SEL_HI 3
`define BWT_STAB_BIT 4
`define BWT_DIV_4096 12'hfff
`define BWT_DIV_1024 12'h3ff
`define BWT_DIV_128 12'h07f
`define BWT_IRQ_OVF 0
`define BWT_IRQ_STAB 1
`define BWT_IRQ_W 2
`endif

// [bwt_pkg.sv]
// types for the basic watchdog / stabilization timer
package bwt_pkg;
   typedef enum logic [2:0] {
      BWT_RUN = 3'h1,
      BWT_STOP = 3'h2,
      BWT_STAB = 3'h4
   } bwt_state_t;
endpackage : bwt_pkg

// [bwt_prescaler.sv]
// prescaler producing a one-cycle tick at the selected division
`include "bwt_defines.svh"
module bwt_prescaler (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_clear,
   input wire logic i_run,
   input wire logic [1:0] i_sel,
   output logic o_tick
);
   logic [11:0] div_reg;
   logic [11:0] div_next;
   logic [11:0] mask;
   logic tick_next;

   // divider counts while i_run is high and holds otherwise; tick when the masked low bits are all ones
   always_comb begin
      case (i_sel)
         2'h0: mask = `BWT_DIV_4096;
         2'h1: mask = `BWT_DIV_1024;
         default: mask = `BWT_DIV_128;
      endcase
      div_next = div_reg;
      tick_next = 1'b0;
      if (i_clear) begin
         div_next = 12'h000;
      end else if (i_run) begin
         div_next = div_reg + 12'h001;
         tick_next = ((div_reg & mask) == mask);
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         div_reg <= 12'h000;
         o_tick <= 1'b0;
      end else begin
         div_reg <= div_next;
         o_tick <= tick_next;
      end
   end
endmodule : bwt_prescaler

// [bwt_timer.sv]
// basic watchdog and oscillation stabilization timer top
`include "bwt_defines.svh"
module bwt_timer
   import bwt_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_stop_req,
   input wire logic i_ext_wake,
   output logic [7:0] o_rdata,
   output logic o_wdt_reset,
   output logic o_cpu_clk_en,
   output logic o_stab_done,
   output logic o_irq
);
   //---------------------------------------------------------------------------
   // pin synchronisers
   //---------------------------------------------------------------------------
   logic [1:0] stop_sync_reg;
   logic [1:0] wake_sync_reg;
   logic stop_s;
   logic wake_s;

   // two flops for the asynchronous stop and wake pins
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         stop_sync_reg <= 2'h0;
         wake_sync_reg <= 2'h0;
      end else begin
         stop_sync_reg <= {stop_sync_reg[0], i_stop_req};
         wake_sync_reg <= {wake_sync_reg[0], i_ext_wake};
      end
   end
   assign stop_s = stop_sync_reg[1];
   assign wake_s = wake_sync_reg[1];

   //---------------------------------------------------------------------------
   // decode helpers
   //---------------------------------------------------------------------------
   function automatic logic wd_enabled(input logic [7:0] ctrl);
      wd_enabled = (ctrl[7:4] != `BWT_DIS_SIG);
   endfunction : wd_enabled

   //---------------------------------------------------------------------------
   // state
   //---------------------------------------------------------------------------
   bwt_state_t state_reg;
   bwt_state_t state_next;
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [7:0] count_reg;
   logic [7:0] count_next;
   logic boot_reg;
   logic boot_next;
   logic [`BWT_IRQ_W-1:0] irq_stat_reg;
   logic [`BWT_IRQ_W-1:0] irq_stat_next;
   logic [`BWT_IRQ_W-1:0] irq_mask_reg;
   logic [`BWT_IRQ_W-1:0] irq_mask_next;
   logic [7:0] rdata_next;
   logic wdt_reset_next;
   logic cpu_en_next;
   logic stab_done_next;
   logic irq_next;
   logic tick;
   logic pre_clear;
   logic [1:0] sel_eff;
   logic ctrl_wr;
   logic overflow;
   logic stab_end;
   logic [`BWT_IRQ_W-1:0] irq_evt;

   assign ctrl_wr = i_wr && (i_addr == `BWT_ADDR_CTRL);
   assign pre_clear = ctrl_wr && i_wdata[`BWT_BIT_PRE_CLR];
   // boot stabilization forces divide 4096, wake uses programmed select
   assign sel_eff = boot_reg ? 2'h0 : ctrl_reg[`BWT_SEL_HI:`BWT_SEL_LO];

   bwt_prescaler u_pre (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_clear(pre_clear),
      .i_run(state_reg != BWT_STOP),
      .i_sel(sel_eff),
      .o_tick(tick)
   );

   //---------------------------------------------------------------------------
   // counter, mode sequencing and control register
   //---------------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      ctrl_next = ctrl_reg;
      count_next = count_reg;
      boot_next = boot_reg;
      overflow = 1'b0;
      stab_end = 1'b0;
      // control writes store select and signature; clear bits self-clear
      // a wake from stop leaves the stored control untouched
      if (ctrl_wr) begin
         ctrl_next = {i_wdata[7:2], 2'h0};
      end
      // counter advances on each prescaler tick outside stop
      if (tick && state_reg != BWT_STOP) begin
         count_next = count_reg + 8'h01;
         overflow = (count_reg == 8'hff);
      end
      if (ctrl_wr && i_wdata[`BWT_BIT_CNT_CLR]) begin
         count_next = 8'h00;
         overflow = 1'b0;
      end
      case (state_reg)
         BWT_RUN: begin
            if (stop_s) begin
               state_next = BWT_STOP;
            end
         end
         BWT_STOP: begin
            if (wake_s) begin
               state_next = BWT_STAB;
               count_next = 8'h00;
            end
         end
         BWT_STAB: begin
            if (count_reg[`BWT_STAB_BIT]) begin
               state_next = BWT_RUN;
               stab_end = 1'b1;
               boot_next = 1'b0;
               count_next = 8'h00;
            end
         end
         default: begin
            state_next = BWT_RUN;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= BWT_STAB;
         ctrl_reg <= `BWT_CTRL_RESET;
         count_reg <= 8'h00;
         boot_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         ctrl_reg <= ctrl_next;
         count_reg <= count_next;
         boot_reg <= boot_next;
      end
   end

   //---------------------------------------------------------------------------
   // interrupt status and mask
   //---------------------------------------------------------------------------
   assign irq_evt[`BWT_IRQ_OVF] = overflow;
   assign irq_evt[`BWT_IRQ_STAB] = stab_end;

   // sticky bits, write one clears, a same-cycle event wins
   always_comb begin
      irq_stat_next = irq_stat_reg;
      irq_mask_next = irq_mask_reg;
      if (i_wr && i_addr == `BWT_ADDR_IRQ_STATUS) begin
         irq_stat_next = irq_stat_reg & ~i_wdata[`BWT_IRQ_W-1:0];
      end
      if (i_wr && i_addr == `BWT_ADDR_IRQ_MASK) begin
         irq_mask_next = i_wdata[`BWT_IRQ_W-1:0];
      end
      irq_stat_next = irq_stat_next | irq_evt;
      irq_next = |(irq_stat_next & irq_mask_next);
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
         o_irq <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         o_irq <= irq_next;
      end
   end

   //---------------------------------------------------------------------------
   // register reads and registered outputs
   //---------------------------------------------------------------------------
   always_comb begin
      rdata_next = 8'h00;
      if (i_rd) begin
         case (i_addr)
            `BWT_ADDR_CTRL: rdata_next = ctrl_reg;
            `BWT_ADDR_COUNT: rdata_next = count_reg;
            `BWT_ADDR_IRQ_STATUS: rdata_next = {6'h00, irq_stat_reg};
            `BWT_ADDR_IRQ_MASK: rdata_next = {6'h00, irq_mask_reg};
            default: rdata_next = 8'h00;
         endcase
      end
      wdt_reset_next = overflow && wd_enabled(ctrl_reg);
      cpu_en_next = (state_next == BWT_RUN);
      stab_done_next = stab_end;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
         o_wdt_reset <= 1'b0;
         o_cpu_clk_en <= 1'b0;
         o_stab_done <= 1'b0;
      end else begin
         o_rdata <= rdata_next;
         o_wdt_reset <= wdt_reset_next;
         o_cpu_clk_en <= cpu_en_next;
         o_stab_done <= stab_done_next;
      end
   end
endmodule : bwt_timer

// [bwt_timer_sva.sv]
// port checker for the watchdog and stabilization timer
module bwt_timer_sva (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_stop_req,
   input wire logic [7:0] o_rdata,
   input wire logic o_wdt_reset,
   input wire logic o_cpu_clk_en,
   input wire logic o_stab_done,
   input wire logic o_irq
);
   logic [7:0] ctl_reg;
   logic [7:0] ctl_next;
   logic [7:0] msk_reg;
   logic [7:0] msk_next;
   // shadow copies of control and mask taken from bus writes
   always_comb begin
      ctl_next = (i_wr && i_addr == 8'hdc) ? i_wdata : ctl_reg;
      msk_next = (i_wr && i_addr == 8'hdf) ? i_wdata : msk_reg;
   end
   // register the shadows
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctl_reg <= 8'h00;
         msk_reg <= 8'h00;
      end else begin
         ctl_reg <= ctl_next;
         msk_reg <= msk_next;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // write that clears the counter, then a counter read
   sequence s_clr; i_wr && i_addr == 8'hdc && i_wdata[1]; endsequence
   sequence s_rd_cnt; i_rd && i_addr == 8'hdd; endsequence
   property p_idle; !i_rd |=> o_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data outside slot");
   property p_unmap; i_rd && i_addr < 8'hdc |=> o_rdata == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_ctl; i_rd && i_addr == 8'hdc |=> o_rdata == {$past(ctl_reg[7:2]), 2'b00}; endproperty
   a_ctl: assert property (p_ctl) else $error("control readback wrong");
   property p_pulse; o_wdt_reset |=> !o_wdt_reset; endproperty
   a_pulse: assert property (p_pulse) else $error("reset pulse too long");
   property p_sig; o_wdt_reset |-> $past(ctl_reg[7:4]) != 4'ha; endproperty
   a_sig: assert property (p_sig) else $error("reset while disabled");
   property p_stab; o_stab_done |-> ##[0:1] o_cpu_clk_en; endproperty
   a_stab: assert property (p_stab) else $error("cpu clock not restored");
   property p_clr; s_clr ##1 s_rd_cnt |=> o_rdata == 8'h00; endproperty
   a_clr: assert property (p_clr) else $error("counter not cleared");
   property p_mask; msk_reg == 8'h00 [*2] |-> !o_irq; endproperty
   a_mask: assert property (p_mask) else $error("masked interrupt seen");
   property p_stop; i_stop_req [*8] |-> !o_cpu_clk_en; endproperty
   a_stop: assert property (p_stop) else $error("cpu clock runs in stop");
endmodule : bwt_timer_sva
bind bwt_timer bwt_timer_sva u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_stop_req(i_stop_req), .o_rdata(o_rdata),
   .o_wdt_reset(o_wdt_reset), .o_cpu_clk_en(o_cpu_clk_en), .o_stab_done(o_stab_done),
   .o_irq(o_irq));

// [basic_watchdog_stabilization_timer_tb_top.sv]
// self-checking bench for the watchdog and stabilization timer
module basic_watchdog_stabilization_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, rd_d = 1'b0;
   logic i_stop_req = 1'b0, i_ext_wake = 1'b0;
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, v, o_rdata;
   logic o_wdt_reset, o_cpu_clk_en, o_stab_done, o_irq;
   logic [7:0] exp_q[$];
   int mismatches = 0, tests_run = 0, n;
   // 100 ns clock
   always #50 i_clk = ~i_clk;
   bwt_timer dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_stop_req(i_stop_req), .i_ext_wake(i_ext_wake),
      .o_rdata(o_rdata), .o_wdt_reset(o_wdt_reset), .o_cpu_clk_en(o_cpu_clk_en),
      .o_stab_done(o_stab_done), .o_irq(o_irq));
   // one bus cycle; a read notes its expected data
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= w;
      i_rd <= ~w;
      i_addr <= a;
      i_wdata <= d;
      if (!w) exp_q.push_back(d);
   endtask : acc
   task automatic idle;
      @(posedge i_clk);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
   endtask : idle
   task automatic chk(input logic a, input logic b);
      tests_run++;
      if (a !== b) begin
         mismatches++;
         $display("FAIL t=%0t level %b exp %b", $time, a, b);
      end
   endtask : chk
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   // flag the cycle in which read data is due
   always @(posedge i_clk) rd_d <= i_rd;
   // compare read data against the oldest note
   always @(negedge i_clk) begin
      if (rd_d) begin
         tests_run++;
         if (o_rdata !== exp_q[0]) begin
            mismatches++;
            $display("FAIL t=%0t read %h exp %h", $time, o_rdata, exp_q[0]);
         end
         void'(exp_q.pop_front());
      end
   end
   // hang guard
   initial begin
      repeat (110000) @(posedge i_clk);
      mismatches++;
      $display("FAIL t=%0t timeout", $time);
      complete_run();
   end
   // main sequence
   initial begin
      void'($urandom(32'he78d));
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
      acc(0, 8'hdc, 8'h00);
      acc(0, 8'h10, 8'h00);
      acc(1, 8'hdd, 8'h55);
      acc(0, 8'hdd, 8'h00);
      idle();
      @(negedge i_clk) chk(o_cpu_clk_en, 1'b0);
      for (n = 0; n < 70000 && o_stab_done !== 1'b1; n++) @(negedge i_clk);
      chk(o_stab_done, 1'b1);
      chk(n > 65000, 1'b1);
      @(negedge i_clk) chk(o_cpu_clk_en, 1'b1);
      $display("test boot done");
      for (int s = 0; s < 4; s++) begin
         v = $urandom;
         v[3:2] = s[1:0];
         acc(1, 8'hdc, v);
         acc(0, 8'hdc, {v[7:2], 2'b00});
      end
      acc(1, 8'hdf, 8'h01);
      acc(1, 8'hdc, 8'h0f);
      acc(0, 8'hdd, 8'h00);
      idle();
      repeat (704) @(posedge i_clk);
      acc(0, 8'hdd, 8'h05);
      idle();
      $display("test control done");
      for (n = 0; n < 33500 && o_wdt_reset !== 1'b1; n++) @(negedge i_clk);
      chk(o_wdt_reset, 1'b1);
      chk(n > 31500, 1'b1);
      repeat (2) @(negedge i_clk) chk(o_irq, 1'b1);
      acc(0, 8'hde, 8'h03);
      acc(1, 8'hdf, 8'h00);
      idle();
      repeat (3) @(negedge i_clk);
      chk(o_irq, 1'b0);
      acc(1, 8'hde, 8'h03);
      acc(0, 8'hde, 8'h00);
      idle();
      $display("test overflow done");
      @(posedge i_clk) i_stop_req <= 1'b1;
      repeat (8) @(negedge i_clk);
      chk(o_cpu_clk_en, 1'b0);
      @(posedge i_clk) i_stop_req <= 1'b0;
      @(posedge i_clk) i_ext_wake <= 1'b1;
      repeat (3) @(posedge i_clk);
      i_ext_wake <= 1'b0;
      for (n = 0; n < 2500 && o_stab_done !== 1'b1; n++) @(negedge i_clk);
      chk(n > 1900 && n < 2200, 1'b1);
      acc(0, 8'hdc, 8'h0c);
      idle();
      $display("test stop done");
      repeat (2) @(posedge i_clk);
      complete_run();
   end
endmodule : basic_watchdog_stabilization_timer_tb_top
